// ---- inc/srs_pkg.sv ----
`default_nettype none
package srs_pkg;
    // Bus geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int MEM_AW = 8;
    localparam int IDX_W = 7;

    // Register addresses; addr[8] low selects the word memory
    localparam logic [8:0] A_CMD = 9'h100;
    localparam logic [8:0] A_SIMD_CONTROL_STATUS_REG = 9'h101;
    localparam logic [8:0] A_FPU_CW = 9'h102;
    localparam logic [8:0] A_FEATURE = 9'h103;
    localparam logic [8:0] A_LANE_CTL = 9'h104;
    localparam logic [8:0] A_LANE_LO = 9'h105;
    localparam logic [8:0] A_LANE_HI = 9'h106;
    localparam logic [8:0] A_CMP = 9'h107;
    localparam logic [8:0] A_FLAGS = 9'h108;
    localparam logic [8:0] A_PINT_BASE = 9'h110;
    localparam logic [8:0] A_EXP_BASE = 9'h120;

    // Save image layout, in words from the image base
    localparam logic [7:0] MEM_IMAGE_BASE = 8'h80;
    localparam logic [6:0] IMG_FPU_BASE = 7'h20;
    localparam logic [6:0] IMG_CTRL = 7'h40;
    localparam logic [6:0] IMG_SIMD_CONTROL_STATUS_REG = 7'h41;
    localparam logic [6:0] IMG_WORDS = 7'h42;

    // Field positions
    localparam int CMD_SAVE_BIT = 0;
    localparam int CMD_RESTORE_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int FEAT_FAST_SAVE_BIT = 24;
    localparam int FEAT_SIMD_BIT = 25;
    localparam int SIMD_CONTROL_STATUS_REG_DAZ_BIT = 6;
    localparam int SIMD_CONTROL_STATUS_REG_FTZ_BIT = 15;
    localparam int FLAG_CF_BIT = 0;
    localparam int FLAG_ZF_BIT = 6;
    localparam int LC_REG_LSB = 0;
    localparam int LC_LANE_LSB = 4;
    localparam int LC_FMT_LSB = 8;
    localparam int LC_W = 11;
    localparam int CMP_B_LSB = 4;

    // Reset and constant values
    localparam logic [31:0] SIMD_CONTROL_STATUS_REG_RESET = 32'h0;
    localparam logic [31:0] FPU_CW_RESET = 32'h0;
    localparam logic [31:0] FLAGS_RESET = 32'h0;
    localparam logic [31:0] FEATURE_VALUE = (32'h1 << FEAT_FAST_SAVE_BIT) | (32'h1 << FEAT_SIMD_BIT);

    // Lane formats of a wide register
    typedef enum logic [2:0] {
        SRS_FMT_BYTE = 3'h0,
        SRS_FMT_WORD = 3'h1,
        SRS_FMT_DWORD = 3'h2,
        SRS_FMT_QWORD = 3'h3,
        SRS_FMT_SCALAR_DP = 3'h4,
        SRS_FMT_PACKED_DP = 3'h5
    } srs_fmt_t;

    // Save/restore sequencer
    typedef enum logic [2:0] {
        SRS_IDLE = 3'b001,
        SRS_SAVE = 3'b010,
        SRS_REST = 3'b100
    } srs_seq_t;
endpackage
`default_nettype wire

// ---- logic/srs_lane.sv ----
`default_nettype none
module srs_lane (
    input wire srs_pkg::srs_fmt_t fmt,
    input wire logic [3:0] lane,
    input wire logic [2:0] reg_idx,
    input wire logic hi,
    input wire logic [31:0] wdata,
    output logic [4:0] word_addr,
    output logic [3:0] be,
    output logic [31:0] lane_data,
    output logic valid
);
    // Map a lane of a wide register onto a memory word and its byte enables
    always_comb begin
        logic [1:0] word;
        word = 2'h0;
        be = 4'hF;
        lane_data = wdata;
        valid = 1'b0;
        unique case (fmt)
            srs_pkg::SRS_FMT_BYTE: begin
                word = lane[3:2];
                be = 4'h1 << lane[1:0];
                lane_data = {4{wdata[7:0]}};
                valid = !hi;
            end
            srs_pkg::SRS_FMT_WORD: begin
                word = lane[2:1];
                be = lane[0] ? 4'hC : 4'h3;
                lane_data = {2{wdata[15:0]}};
                valid = !hi && !lane[3];
            end
            srs_pkg::SRS_FMT_DWORD: begin
                word = lane[1:0];
                valid = !hi && (lane[3:2] == 2'h0);
            end
            srs_pkg::SRS_FMT_QWORD, srs_pkg::SRS_FMT_PACKED_DP: begin
                word = {lane[0], hi};
                valid = (lane[3:1] == 3'h0);
            end
            srs_pkg::SRS_FMT_SCALAR_DP: begin
                word = {1'b0, hi}; // Low quadword only, high one passes through untouched
                valid = (lane == 4'h0);
            end
            default: begin
                valid = 1'b0;
            end
        endcase
        word_addr = {reg_idx, word};
    end
endmodule
`default_nettype wire

// ---- logic/srs_mem.sv ----
`default_nettype none
module srs_mem #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW/8-1:0] wbe,
    input wire logic [DW-1:0] wdata,
    input wire logic rd_en,
    input wire logic [AW-1:0] raddr,
    input wire logic ld_en,
    input wire logic [DW-1:0] ld_data,
    output wire logic [DW-1:0] q
);
    // One storage column per byte lane so byte enables need no read-modify-write
    for (genvar b = 0; b < DW / 8; b++) begin : g_lane
        logic [7:0] cell_q [2**AW];
        logic [7:0] out_q;

        always_ff @(posedge clk) begin
            if (clk_en && we && wbe[b]) begin
                cell_q[waddr] <= wdata[8*b +: 8];
            end
        end

        // Output register also takes a loaded word, so every reader sees one register
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                out_q <= 8'h00;
            end else if (clk_en) begin
                if (rd_en) begin
                    out_q <= cell_q[raddr];
                end else if (ld_en) begin
                    out_q <= ld_data[8*b +: 8];
                end
            end
        end

        assign q[8*b +: 8] = out_q;
    end
endmodule
`default_nettype wire

// ---- logic/srs_state.sv ----
`default_nettype none
// How it works
// - Save and restore copy the whole legacy FPU state, so the aliased packed-integer registers travel with it.
// - Save and restore also copy all eight wide registers and the SIMD control/status register.
// - The feature word reports the fast save/restore operations on bit 24.
// - The SIMD flag on bit 25 is a separate bit and says nothing about save/restore.
// - The second SIMD generation adds no state, so the save image holds nothing beyond the first.
// - Eight 128-bit wide registers, indexed 0 to 7, hold float or integer data.
// - Scalar double values live in the low quadword and leave the high one untouched.
// - Packed double values sit as two 64-bit lanes of one wide register.
// - Wide registers take byte, word, doubleword and quadword integer lanes.
// - The control/status register is 32 bits and carries the two denormal speed-up flags.
// - Eight 64-bit packed-integer registers, indexed 0 to 7, can feed combined operations.
// - Addresses come only from general registers; no SIMD register is an address source.
// - General-register values can be written into or read from the SIMD registers.
// - Compares record their outcome in the 32-bit processor flags word.
// - The logic works the same in every execution mode.
// - The denormal-source-as-zero flag is bit 6 of the control/status register.
module srs_state (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [srs_pkg::ADDR_W-1:0] addr,
    input wire logic [srs_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output wire logic [srs_pkg::DATA_W-1:0] rd_data,
    output logic busy,
    output wire logic denormal_as_zero,
    output wire logic flush_to_zero,
    output logic [srs_pkg::DATA_W-1:0] proc_flags
);
    logic [31:0] simd_control_status_reg_q;
    logic [31:0] fpu_cw_q;
    logic [63:0] fpu_mant_q [8];
    logic [15:0] fpu_exp_q [8];
    logic [srs_pkg::LC_W-1:0] lane_ctl_q;
    logic [7:0] cmp_sel_q;
    srs_pkg::srs_seq_t state_q;
    logic [6:0] idx_q;
    logic [6:0] pidx_q;
    logic pend_q;
    logic [6:0] wcnt_q;

    logic sw_mem, is_lane, sw_wr_ok, cmd_wr, seq_issue, rest_wr;
    logic [31:0] reg_rd_word, save_word, flags_d;
    logic cmp_eq;
    logic m_we, m_rd_en, m_ld_en;
    logic [7:0] m_waddr, m_raddr;
    logic [3:0] m_wbe;
    logic [31:0] m_wdata, m_ld_data, mem_q;
    logic [4:0] l_addr;
    logic [3:0] l_be;
    logic [31:0] l_data;
    logic l_valid;
    srs_pkg::srs_fmt_t lane_fmt;

    // Access decode; no execution-mode input exists, so every mode sees the same map
    always_comb begin
        sw_mem = !addr[8];
        is_lane = (addr == srs_pkg::A_LANE_LO) || (addr == srs_pkg::A_LANE_HI);
        sw_wr_ok = wr_stb && !busy;
        cmd_wr = sw_wr_ok && (addr == srs_pkg::A_CMD);
        seq_issue = busy && !rd_stb && (idx_q < srs_pkg::IMG_WORDS);
        rest_wr = busy && pend_q && (state_q == srs_pkg::SRS_REST);
        lane_fmt = srs_pkg::srs_fmt_t'(lane_ctl_q[srs_pkg::LC_FMT_LSB +: 3]);
    end

    // Lane view of the selected wide register for general-register transfers
    srs_lane u_lane (
        .fmt(lane_fmt),
        .lane(lane_ctl_q[srs_pkg::LC_LANE_LSB +: 4]),
        .reg_idx(lane_ctl_q[srs_pkg::LC_REG_LSB +: 3]),
        .hi(addr == srs_pkg::A_LANE_HI),
        .wdata(wr_data),
        .word_addr(l_addr),
        .be(l_be),
        .lane_data(l_data),
        .valid(l_valid)
    );

    // Readback of flop registers
    always_comb begin
        reg_rd_word = 32'h0;
        if (addr[8:4] == srs_pkg::A_PINT_BASE[8:4]) begin
            reg_rd_word = addr[0] ? fpu_mant_q[addr[3:1]][63:32] : fpu_mant_q[addr[3:1]][31:0];
        end else if (addr[8:3] == srs_pkg::A_EXP_BASE[8:3]) begin
            reg_rd_word = {16'h0, fpu_exp_q[addr[2:0]]};
        end else begin
            unique case (addr)
                srs_pkg::A_CMD: reg_rd_word[srs_pkg::STAT_BUSY_BIT] = busy;
                srs_pkg::A_SIMD_CONTROL_STATUS_REG: reg_rd_word = simd_control_status_reg_q;
                srs_pkg::A_FPU_CW: reg_rd_word = fpu_cw_q;
                srs_pkg::A_FEATURE: reg_rd_word = srs_pkg::FEATURE_VALUE;
                srs_pkg::A_LANE_CTL: reg_rd_word = {21'h0, lane_ctl_q};
                srs_pkg::A_CMP: reg_rd_word = {24'h0, cmp_sel_q};
                srs_pkg::A_FLAGS: reg_rd_word = proc_flags;
                default: reg_rd_word = 32'h0;
            endcase
        end
    end

    // Flop-held words of the save image; the layout holds only first-generation state
    always_comb begin
        save_word = 32'h0;
        if (idx_q == srs_pkg::IMG_CTRL) begin
            save_word = fpu_cw_q;
        end else if (idx_q == srs_pkg::IMG_SIMD_CONTROL_STATUS_REG) begin
            save_word = simd_control_status_reg_q;
        end else begin
            unique case (idx_q[1:0])
                2'h0: save_word = fpu_mant_q[idx_q[4:2]][31:0];
                2'h1: save_word = fpu_mant_q[idx_q[4:2]][63:32];
                2'h2: save_word = {16'h0, fpu_exp_q[idx_q[4:2]]};
                2'h3: save_word = 32'h0;
            endcase
        end
    end

    // Read port: software reads win, the sequencer just waits a cycle
    always_comb begin
        m_rd_en = 1'b0;
        m_raddr = 8'h00;
        m_ld_en = 1'b0;
        m_ld_data = 32'h0;
        if (rd_stb) begin
            if (sw_mem) begin
                m_rd_en = 1'b1;
                m_raddr = addr[7:0];
            end else if (is_lane) begin
                m_rd_en = 1'b1;
                m_raddr = {3'h0, l_addr};
            end else begin
                m_ld_en = 1'b1;
                m_ld_data = reg_rd_word;
            end
        end else if (seq_issue) begin
            // Image addresses come from the step counter, never from register contents
            if (state_q == srs_pkg::SRS_REST) begin
                m_rd_en = 1'b1;
                m_raddr = srs_pkg::MEM_IMAGE_BASE | {1'b0, idx_q};
            end else if (idx_q < srs_pkg::IMG_FPU_BASE) begin
                m_rd_en = 1'b1;
                m_raddr = {1'b0, idx_q};
            end else begin
                m_ld_en = 1'b1;
                m_ld_data = save_word;
            end
        end
    end

    // Write port: the sequencer owns it while busy, software writes are dropped then
    always_comb begin
        m_we = 1'b0;
        m_waddr = 8'h00;
        m_wbe = 4'hF;
        m_wdata = mem_q;
        if (busy) begin
            if (pend_q && (state_q == srs_pkg::SRS_SAVE)) begin
                m_we = 1'b1;
                m_waddr = srs_pkg::MEM_IMAGE_BASE | {1'b0, pidx_q};
            end else if (rest_wr && (pidx_q < srs_pkg::IMG_FPU_BASE)) begin
                m_we = 1'b1;
                m_waddr = {1'b0, pidx_q};
            end
        end else if (wr_stb) begin
            if (sw_mem) begin
                m_we = 1'b1;
                m_waddr = addr[7:0];
                m_wdata = wr_data;
            end else if (is_lane && l_valid) begin
                m_we = 1'b1;
                m_waddr = {3'h0, l_addr};
                m_wbe = l_be;
                m_wdata = l_data;
            end
        end
    end

    // Eight 128-bit wide registers are words 0 to 31, the save image sits above them
    srs_mem #(
        .AW(srs_pkg::MEM_AW),
        .DW(srs_pkg::DATA_W)
    ) u_mem (
        .clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .we(m_we),
        .waddr(m_waddr),
        .wbe(m_wbe),
        .wdata(m_wdata),
        .rd_en(m_rd_en),
        .raddr(m_raddr),
        .ld_en(m_ld_en),
        .ld_data(m_ld_data),
        .q(mem_q)
    );

    assign rd_data = mem_q;

    // Sequencer: one issue per free cycle, the write follows one cycle behind
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= srs_pkg::SRS_IDLE;
            busy <= 1'b0;
            idx_q <= 7'h00;
            pidx_q <= 7'h00;
            pend_q <= 1'b0;
        end else if (clk_en) begin
            pend_q <= seq_issue;
            if (seq_issue) begin
                pidx_q <= idx_q;
                idx_q <= idx_q + 7'h01;
            end
            unique case (state_q)
                srs_pkg::SRS_IDLE: begin
                    idx_q <= 7'h00;
                    if (cmd_wr && wr_data[srs_pkg::CMD_SAVE_BIT]) begin
                        state_q <= srs_pkg::SRS_SAVE;
                        busy <= 1'b1;
                    end else if (cmd_wr && wr_data[srs_pkg::CMD_RESTORE_BIT]) begin
                        state_q <= srs_pkg::SRS_REST;
                        busy <= 1'b1;
                    end
                end
                srs_pkg::SRS_SAVE, srs_pkg::SRS_REST: begin
                    if ((idx_q == srs_pkg::IMG_WORDS) && !pend_q) begin
                        state_q <= srs_pkg::SRS_IDLE;
                        busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Count of image words moved in the current operation
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wcnt_q <= 7'h00;
        end else if (clk_en) begin
            if (!busy) begin
                wcnt_q <= 7'h00;
            end else if (pend_q) begin
                wcnt_q <= wcnt_q + 7'h01;
            end
        end
    end

    // Legacy FPU data registers; the low 64 bits are the packed-integer registers
    for (genvar r = 0; r < 8; r++) begin : g_fpu
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                fpu_mant_q[r] <= 64'h0;
                fpu_exp_q[r] <= 16'h0;
            end else if (clk_en) begin
                if (rest_wr && (pidx_q[6:5] == 2'h1) && (pidx_q[4:2] == 3'(r))) begin
                    unique case (pidx_q[1:0])
                        2'h0: fpu_mant_q[r][31:0] <= mem_q;
                        2'h1: fpu_mant_q[r][63:32] <= mem_q;
                        2'h2: fpu_exp_q[r] <= mem_q[15:0];
                        2'h3: ;
                    endcase
                end else if (sw_wr_ok && (addr[8:4] == srs_pkg::A_PINT_BASE[8:4]) && (addr[3:1] == 3'(r))) begin
                    if (addr[0]) begin
                        fpu_mant_q[r][63:32] <= wr_data;
                    end else begin
                        fpu_mant_q[r][31:0] <= wr_data;
                    end
                end else if (sw_wr_ok && (addr[8:3] == srs_pkg::A_EXP_BASE[8:3]) && (addr[2:0] == 3'(r))) begin
                    fpu_exp_q[r] <= wr_data[15:0];
                end
            end
        end
    end

    // Control/status words; a restore overrides nothing because software is locked out
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            simd_control_status_reg_q <= srs_pkg::SIMD_CONTROL_STATUS_REG_RESET;
            fpu_cw_q <= srs_pkg::FPU_CW_RESET;
        end else if (clk_en) begin
            if (rest_wr && (pidx_q == srs_pkg::IMG_SIMD_CONTROL_STATUS_REG)) begin
                simd_control_status_reg_q <= mem_q;
            end else if (sw_wr_ok && (addr == srs_pkg::A_SIMD_CONTROL_STATUS_REG)) begin
                simd_control_status_reg_q <= wr_data;
            end
            if (rest_wr && (pidx_q == srs_pkg::IMG_CTRL)) begin
                fpu_cw_q <= mem_q;
            end else if (sw_wr_ok && (addr == srs_pkg::A_FPU_CW)) begin
                fpu_cw_q <= wr_data;
            end
        end
    end

    assign denormal_as_zero = simd_control_status_reg_q[srs_pkg::SIMD_CONTROL_STATUS_REG_DAZ_BIT];
    assign flush_to_zero = simd_control_status_reg_q[srs_pkg::SIMD_CONTROL_STATUS_REG_FTZ_BIT];

    // Compare of two packed-integer registers, unsigned
    always_comb begin
        cmp_eq = fpu_mant_q[wr_data[2:0]] == fpu_mant_q[wr_data[srs_pkg::CMP_B_LSB +: 3]];
        flags_d = srs_pkg::FLAGS_RESET;
        flags_d[srs_pkg::FLAG_ZF_BIT] = cmp_eq;
        flags_d[srs_pkg::FLAG_CF_BIT] = fpu_mant_q[wr_data[2:0]] < fpu_mant_q[wr_data[srs_pkg::CMP_B_LSB +: 3]];
    end

    // Lane selection, compare selection and the flags word
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lane_ctl_q <= 11'h000;
            cmp_sel_q <= 8'h00;
            proc_flags <= srs_pkg::FLAGS_RESET;
        end else if (clk_en) begin
            if (sw_wr_ok && (addr == srs_pkg::A_LANE_CTL)) begin
                lane_ctl_q <= wr_data[srs_pkg::LC_W-1:0];
            end
            if (sw_wr_ok && (addr == srs_pkg::A_CMP)) begin
                cmp_sel_q <= wr_data[7:0];
                proc_flags <= flags_d;
            end
        end
    end

    property p_feat_fast;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && rd_stb && addr == srs_pkg::A_FEATURE) |=> rd_data[srs_pkg::FEAT_FAST_SAVE_BIT];
    endproperty
    a_feat_fast: assert property (p_feat_fast) else $error("fast save flag missing");

    property p_feat_sep;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && rd_stb && addr == srs_pkg::A_FEATURE) |=> rd_data == srs_pkg::FEATURE_VALUE;
    endproperty
    a_feat_sep: assert property (p_feat_sep) else $error("feature word wrong");

    property p_save_len;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(busy) |-> wcnt_q == srs_pkg::IMG_WORDS;
    endproperty
    a_save_len: assert property (p_save_len) else $error("save or restore moved wrong word count");

    property p_save_simd_control_status_reg;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && seq_issue && state_q == srs_pkg::SRS_SAVE && idx_q == srs_pkg::IMG_SIMD_CONTROL_STATUS_REG)
            |=> mem_q == $past(simd_control_status_reg_q);
    endproperty
    a_save_simd_control_status_reg: assert property (p_save_simd_control_status_reg) else $error("control/status word not saved");

    property p_simd_control_status_reg_wr;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && sw_wr_ok && addr == srs_pkg::A_SIMD_CONTROL_STATUS_REG) |=> simd_control_status_reg_q == $past(wr_data);
    endproperty
    a_simd_control_status_reg_wr: assert property (p_simd_control_status_reg_wr) else $error("control/status write lost");

    property p_daz;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && sw_wr_ok && addr == srs_pkg::A_SIMD_CONTROL_STATUS_REG) |=> denormal_as_zero == $past(wr_data[6]);
    endproperty
    a_daz: assert property (p_daz) else $error("denormal flag not on bit 6");

    property p_scalar;
        @(posedge sys_clk) disable iff (!resetn)
        (sw_wr_ok && is_lane && lane_fmt == srs_pkg::SRS_FMT_SCALAR_DP && m_we) |-> !m_waddr[1];
    endproperty
    a_scalar: assert property (p_scalar) else $error("scalar write left low quadword");

    property p_pd;
        @(posedge sys_clk) disable iff (!resetn)
        (sw_wr_ok && is_lane && lane_fmt == srs_pkg::SRS_FMT_PACKED_DP && m_we)
            |-> m_waddr[1] == lane_ctl_q[srs_pkg::LC_LANE_LSB];
    endproperty
    a_pd: assert property (p_pd) else $error("packed double lane misplaced");

    property p_byte;
        @(posedge sys_clk) disable iff (!resetn)
        (sw_wr_ok && is_lane && lane_fmt == srs_pkg::SRS_FMT_BYTE && m_we) |-> $onehot(m_wbe);
    endproperty
    a_byte: assert property (p_byte) else $error("byte lane wrote more than one byte");

    property p_cmp;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && sw_wr_ok && addr == srs_pkg::A_CMP) |=> proc_flags[srs_pkg::FLAG_ZF_BIT] == $past(cmp_eq);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare result not in flags");
endmodule
`default_nettype wire

// ---- verif/srs_state_tb_top.sv ----
`default_nettype none
module srs_state_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [31:0] wr_data = 32'h0;
    wire logic [31:0] rd_data;
    wire logic [31:0] flags;
    wire logic busy;
    wire logic daz;
    wire logic ftz;
    logic [31:0] rdv, fcw, mx, ef;
    logic [31:0] m[0:255];
    logic [31:0] pm[0:23];
    longint unsigned va, vb;
    int lf, ln, lr, h, lw, off;
    bit v;
    logic [31:0] ld;
    int fails = 0;
    int cmp_count = 0;
    int seed = 68101;
    int n;

    srs_state i_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .busy(busy), .denormal_as_zero(daz),
        .flush_to_zero(ftz), .proc_flags(flags));

    // Free-running system clock
    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string msg);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // Bus cycles end just after the taking edge, once its updates have landed
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask

    // Fill every saved register with fresh random values
    task automatic setall();
        for (int i = 0; i < 32; i++) begin
            m[i] = $random(seed);
            wr(9'(i), m[i]);
        end
        for (int i = 0; i < 24; i++) begin
            pm[i] = (i < 16) ? $random(seed) : ($random(seed) & 32'h0000FFFF);
            wr((i < 16) ? srs_pkg::A_PINT_BASE + 9'(i) : srs_pkg::A_EXP_BASE + 9'(i - 16), pm[i]);
        end
        fcw = $random(seed);
        wr(srs_pkg::A_FPU_CW, fcw);
        mx = $random(seed);
        wr(srs_pkg::A_SIMD_CONTROL_STATUS_REG, mx);
    endtask

    // Bounded wait so a stuck sequencer cannot hang the run
    task automatic waitidle();
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk(32'(busy), 32'h0, "busy stuck");
    endtask

    task automatic test_done();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog sized well above the thousand or so cycles the tests need
    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        chk({busy, daz, ftz, 29'h0} | flags | rd_data, 32'h0, "reset outputs");
        resetn <= 1'b1;
        rd(srs_pkg::A_FEATURE, rdv);
        chk(rdv, 32'h03000000, "feature word");
        rd(9'h10F, rdv);
        chk(rdv, 32'h0, "unmapped read");
        $display("test feature done");
        for (int k = 0; k < 4; k++) begin
            mx = $random(seed);
            wr(srs_pkg::A_SIMD_CONTROL_STATUS_REG, mx);
            chk(32'(daz), 32'(mx[6]), "denormal flag");
            chk(32'(ftz), 32'(mx[15]), "flush flag");
            rd(srs_pkg::A_SIMD_CONTROL_STATUS_REG, rdv);
            chk(rdv, mx, "control readback");
        end
        $display("test control done");
        setall();
        pm[2] = pm[0];
        pm[3] = pm[1];
        wr(srs_pkg::A_PINT_BASE + 9'h002, pm[2]);
        wr(srs_pkg::A_PINT_BASE + 9'h003, pm[3]);
        for (int k = 0; k < 8; k++) begin
            va = {pm[2 * k + 1], pm[2 * k]};
            vb = {pm[2 * ((k + 1) % 8) + 1], pm[2 * ((k + 1) % 8)]};
            ef = (32'(va == vb) << 6) | 32'(va < vb);
            wr(srs_pkg::A_CMP, 32'(k) | (32'((k + 1) % 8) << 4));
            chk(flags, ef, "compare flags");
            rd(srs_pkg::A_FLAGS, rdv);
            chk(rdv, ef, "flags readback");
        end
        $display("test compare done");
        wr(srs_pkg::A_CMD, 32'h1);
        wr(srs_pkg::A_SIMD_CONTROL_STATUS_REG, ~mx);
        waitidle();
        chk(32'(daz), 32'(mx[6]), "write while busy");
        for (int i = 0; i < 66; i++) begin
            m[128 + i] = (i < 32) ? m[i] : (i == 64) ? fcw : (i == 65) ? mx : ((i - 32) % 4 == 3) ? 32'h0 :
                ((i - 32) % 4 == 2) ? pm[16 + (i - 32) / 4] : pm[2 * ((i - 32) / 4) + (i - 32) % 4];
            rd(9'(srs_pkg::MEM_IMAGE_BASE) + 9'(i), rdv);
            chk(rdv, m[128 + i], "save image word");
        end
        $display("test save done");
        setall();
        wr(srs_pkg::A_CMD, 32'h2);
        waitidle();
        for (int i = 0; i < 32; i++) m[i] = m[128 + i];
        for (int r = 0; r < 8; r++) begin
            pm[2 * r] = m[160 + 4 * r];
            pm[2 * r + 1] = m[161 + 4 * r];
            pm[16 + r] = m[162 + 4 * r];
        end
        fcw = m[192];
        mx = m[193];
        for (int i = 0; i < 32; i++) begin
            rd(9'(i), rdv);
            chk(rdv, m[i], "wide register restore");
        end
        for (int i = 0; i < 24; i++) begin
            rd((i < 16) ? srs_pkg::A_PINT_BASE + 9'(i) : srs_pkg::A_EXP_BASE + 9'(i - 16), rdv);
            chk(rdv, pm[i], "fpu restore");
        end
        rd(srs_pkg::A_FPU_CW, rdv);
        chk(rdv, fcw, "fpu control restore");
        rd(srs_pkg::A_SIMD_CONTROL_STATUS_REG, rdv);
        chk(rdv, mx, "control restore");
        chk(32'(daz), 32'(mx[6]), "restored flag");
        $display("test restore done");
        // Random lane writes, illegal lanes and formats included, against a byte model
        for (int k = 0; k < 32; k++) begin
            lf = k % 8;
            ln = $random(seed) & 15;
            lr = $random(seed) & 7;
            h = $random(seed) & 1;
            ld = $random(seed);
            lw = (lf < 3) ? 1 << lf : 4;
            off = (lf < 3) ? ln << lf : ln * 8 + h * 4;
            v = lf < 6 && (lf > 2 || h == 0) && ln < ((lf < 3) ? 16 >> lf : (lf == 4) ? 1 : 2);
            wr(srs_pkg::A_LANE_CTL, 32'(lf * 256 + ln * 16 + lr));
            wr(h ? srs_pkg::A_LANE_HI : srs_pkg::A_LANE_LO, ld);
            if (v) begin
                for (int j = 0; j < lw; j++) begin
                    m[4 * lr + (off + j) / 4][8 * ((off + j) % 4) +: 8] = ld[8 * j +: 8];
                end
                rd(h ? srs_pkg::A_LANE_HI : srs_pkg::A_LANE_LO, rdv);
                chk(rdv, m[4 * lr + off / 4], "lane read");
            end
            for (int i = 0; i < 4; i++) begin
                rd(9'(4 * lr + i), rdv);
                chk(rdv, m[4 * lr + i], "lane write");
            end
        end
        $display("test lane done");
        test_done();
    end
endmodule
`default_nettype wire
